// *** logic/burst_addr_gen.sv ***
// Burst column generator with block wrap and interleave ordering
`timescale 1ns/1ps
module burst_addr_gen (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  burst_if.gen     bif
);
  import flash_burst_pkg::*;

  col_t base_ff;
  col_t nxt_base;
  col_t cnt_ff;
  col_t nxt_cnt;
  col_t mask_ff;
  col_t nxt_mask;
  logic ilv_ff;
  logic nxt_ilv;
  col_t offset;

  always_comb begin
    nxt_base = base_ff;
    nxt_cnt  = cnt_ff;
    nxt_mask = mask_ff;
    nxt_ilv  = ilv_ff;
    if (bif.start) begin
      nxt_base = bif.start_col;
      nxt_cnt  = 8'h01;
      nxt_mask = bif.mask;
      nxt_ilv  = bif.interleave;
    end else if (bif.step) begin
      nxt_cnt  = cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      base_ff <= 8'h00;
      cnt_ff  <= 8'h00;
      mask_ff <= 8'h00;
      ilv_ff  <= 1'b0;
    end else if (clk_en) begin
      base_ff <= nxt_base;
      cnt_ff  <= nxt_cnt;
      mask_ff <= nxt_mask;
      ilv_ff  <= nxt_ilv;
    end
  end

  always_comb begin
    if (ilv_ff) begin
      offset = (base_ff & mask_ff) ^ cnt_ff;
    end else begin
      offset = base_ff + cnt_ff;
    end
    if (bif.start) begin
      bif.col = bif.start_col;
    end else begin
      bif.col = (base_ff & ~mask_ff) | (offset & mask_ff);
    end
  end

endmodule

// *** logic/burst_if.sv ***
// Burst column sequencing signals between control and generator
`timescale 1ns/1ps
interface burst_if;
  logic       start;
  logic       step;
  logic       interleave;
  logic [7:0] start_col;
  logic [7:0] mask;
  logic [7:0] col;

  modport ctrl (
    output start,
    output step,
    output interleave,
    output start_col,
    output mask,
    input  col
  );

  modport gen (
    input  start,
    input  step,
    input  interleave,
    input  start_col,
    input  mask,
    output col
  );
endinterface

// *** logic/flash_burst_pkg.sv ***
// Types and the burst mask decode function of the burst command block
package flash_burst_pkg;

  typedef logic [7:0]  col_t;
  typedef logic [11:0] row_t;
  typedef logic [15:0] word_t;
  typedef logic [10:0] mode_t;

  typedef enum logic [3:0] {
    CMD_NOP   = 4'h0,
    CMD_ACT   = 4'h1,
    CMD_RD    = 4'h2,
    CMD_WR    = 4'h3,
    CMD_BST   = 4'h4,
    CMD_CLOSE = 4'h5,
    CMD_CODE  = 4'h6,
    CMD_MRS   = 4'h7
  } cmd_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } state_e;

  // Column mask of the wrap block for a burst length code
  function automatic col_t burst_mask(input logic [2:0] bl);
    case (bl)
      3'h1:    burst_mask = 8'h01;
      3'h2:    burst_mask = 8'h03;
      3'h3:    burst_mask = 8'h07;
      3'h7:    burst_mask = 8'hFF;
      default: burst_mask = 8'h00;
    endcase
  endfunction

endpackage

// *** logic/flash_burst_regs.svh ***
// Mode register layout, encodings and fixed counts of the burst command block
`ifndef FLASH_BURST_REGS_SVH
`define FLASH_BURST_REGS_SVH

`define MR_WIDTH        11
`define MR_BL_LSB       0
`define MR_BL_MSB       2
`define MR_BT_BIT       3
`define MR_CL_LSB       4
`define MR_CL_MSB       6
`define MR_OPM_LSB      7
`define MR_OPM_MSB      8
`define MR_WB_BIT       9
`define MR_RESET        11'h020

`define BL_ONE          3'h0
`define BL_TWO          3'h1
`define BL_FOUR         3'h2
`define BL_EIGHT        3'h3
`define BL_FULL         3'h7

`define CL_ONE          3'h1
`define CL_TWO          3'h2

`define ADDR_ALL_BANKS  10
`define CODE_MSB        7
`define COL_MSB         7
`define WR_FULL_MASK    8'h07

`endif

// *** logic/sdram_flash_burst_cmd.sv ***
// Command decode, mode register and burst data path of the flash SDRAM port
//
// Overview of operation
// - Lengths 2/4/8 pick block from upper column bits, start from low bits.
// - Full-page burst spans the whole 256-column row from any start column.
// - A burst reaching its block end wraps to the start of that block.
// - Order follows length, start and order bit; sequential adds, else XOR.
// - Burst length one touches just the named column; order bit ignored.
// - First read word valid latency clocks after the read, latency 1 to 3.
// - Data pins start driving in the same clock as the first valid read word.
// - Write-burst select clear: writes use length; full page gives eight.
// - Write-burst select set: every write is a single location.
// - Chip select high inhibits; strobes high are no-op; activate opens row.
// - Read, write and burst terminate decode; column is eight bits.
// - Row close shuts one bank, or all when address bit ten is high.
// - Command-code load takes low eight address bits, starts flash sequence.
// - With code load disabled, refresh encodings act as no-operations.
// - Load mode register takes op-code from low eleven address bits.
// - Initialization copies the stored default into the mode register.
// - Output mask acts at once on writes, two clocks late on reads.
// - Configuration readout returns the current mode register contents.
// - Full page is sequential read only; interleave supports 1, 2, 4, 8.
`timescale 1ns/1ps
`include "flash_burst_regs.svh"
module sdram_flash_burst_cmd (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire logic                  cs_n,
  input  wire logic                  ras_n,
  input  wire logic                  cas_n,
  input  wire logic                  we_n,
  input  wire logic [1:0]            bank_sel,
  input  wire logic [11:0]           addr,
  input  wire logic                  dqm,
  input  wire flash_burst_pkg::word_t dq_in,
  output       flash_burst_pkg::word_t dq_out,
  output logic                       dq_oe,
  input  wire logic                  init_load,
  input  wire flash_burst_pkg::mode_t nv_mode_value,
  input  wire logic                  hw_code_load_off,
  input  wire logic                  cfg_read_sel,
  output logic                       rd_en,
  output logic [1:0]                 rd_bank,
  output       flash_burst_pkg::row_t rd_row,
  output       flash_burst_pkg::col_t rd_col,
  input  wire flash_burst_pkg::word_t rd_data,
  output logic                       wr_en,
  output logic [1:0]                 wr_bank,
  output       flash_burst_pkg::row_t wr_row,
  output       flash_burst_pkg::col_t wr_col,
  output       flash_burst_pkg::word_t wr_data,
  output logic [7:0]                 cmd_code,
  output logic                       cmd_code_vld,
  output logic [3:0]                 bank_open,
  output       flash_burst_pkg::mode_t mode_value
);
  import flash_burst_pkg::*;

  burst_if bif ();

  cmd_e       cmd;
  state_e     st_ff, nxt_st;
  logic [8:0] rem_ff, nxt_rem;
  logic [1:0] bbank_ff, nxt_bbank, wr_bank_ff;
  mode_t      mode_ff, nxt_mode;
  logic [7:0] code_ff, nxt_code;
  logic       code_vld_ff, nxt_code_vld;
  row_t       row_ff [4], wr_row_ff;
  logic [3:0] open_ff;
  logic [2:0] bl, cl;
  logic       full_pg, rd_word, wr_word, start_rd, start_wr;
  col_t       wmask, wr_col_ff;
  word_t      pipe_ff [2], nxt_pipe [2];
  logic [1:0] pvld_ff, nxt_pvld;
  word_t      dout_ff, nxt_dout, wr_data_ff, cur_word;
  logic       oe_ff, nxt_oe, dqm_d1_ff, sel_vld;
  logic       wr_en_ff, nxt_wr_en;

  assign bl      = mode_ff[`MR_BL_MSB:`MR_BL_LSB];
  assign cl      = mode_ff[`MR_CL_MSB:`MR_CL_LSB];
  assign full_pg = (bl == `BL_FULL);

  // Command decode from the strobe pins
  always_comb begin
    cmd = CMD_NOP;
    if (clk_en && !cs_n) begin
      unique case ({ras_n, cas_n, we_n})
        3'b011:  cmd = CMD_ACT;
        3'b101:  cmd = CMD_RD;
        3'b100:  cmd = CMD_WR;
        3'b110:  cmd = CMD_BST;
        3'b010:  cmd = CMD_CLOSE;
        3'b001:  cmd = hw_code_load_off ? CMD_NOP : CMD_CODE;
        3'b000:  cmd = CMD_MRS;
        3'b111:  cmd = CMD_NOP;
      endcase
    end
  end

  assign start_rd = (cmd == CMD_RD);
  assign start_wr = (cmd == CMD_WR);

  // full page writes in blocks of eight
  always_comb begin
    if (mode_ff[`MR_WB_BIT]) begin
      wmask = 8'h00;
    end else if (full_pg) begin
      wmask = `WR_FULL_MASK;
    end else begin
      wmask = burst_mask(bl);
    end
  end

  // terminate, a read or a write ends the running burst
  assign rd_word = start_rd || (st_ff == ST_READ && cmd != CMD_WR &&
                   cmd != CMD_BST);
  assign wr_word = start_wr || (st_ff == ST_WRITE && cmd != CMD_RD &&
                   cmd != CMD_BST);

  // length one has an empty mask
  assign bif.start      = start_rd || start_wr;
  assign bif.step       = (rd_word || wr_word) && !bif.start;
  assign bif.start_col  = addr[`COL_MSB:0];
  assign bif.mask       = start_wr ? wmask : burst_mask(bl);
  assign bif.interleave = mode_ff[`MR_BT_BIT] && !full_pg;

  burst_addr_gen burst_addr_gen_i (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .bif     (bif)
  );

  // Burst length counter and state
  always_comb begin
    nxt_st    = st_ff;
    nxt_rem   = rem_ff;
    nxt_bbank = bbank_ff;
    if (bif.start) begin
      nxt_bbank = bank_sel;
      nxt_rem   = {1'b0, bif.mask};
      if (bif.mask == 8'h00) begin
        nxt_st = ST_IDLE;
      end else begin
        nxt_st = start_rd ? ST_READ : ST_WRITE;
      end
    end else if (rd_word || wr_word) begin
      if (!(rd_word && full_pg)) begin
        nxt_rem = rem_ff - 9'h001;
        if (rem_ff == 9'h001) begin
          nxt_st = ST_IDLE;
        end
      end
    end else if (st_ff != ST_IDLE) begin
      nxt_st = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff    <= ST_IDLE;
      rem_ff   <= 9'h000;
      bbank_ff <= 2'h0;
    end else if (clk_en) begin
      st_ff    <= nxt_st;
      rem_ff   <= nxt_rem;
      bbank_ff <= nxt_bbank;
    end
  end

  // Per-bank open row tracking
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_bank
      row_t nxt_row;
      logic nxt_open;
      always_comb begin
        nxt_row  = row_ff[b];
        nxt_open = open_ff[b];
        if (cmd == CMD_ACT && bank_sel == b) begin
          nxt_row  = addr;
          nxt_open = 1'b1;
        end
        if (cmd == CMD_CLOSE && (addr[`ADDR_ALL_BANKS] || bank_sel == b)) begin
          nxt_open = 1'b0;
        end
      end
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          row_ff[b]  <= 12'h000;
          open_ff[b] <= 1'b0;
        end else if (clk_en) begin
          row_ff[b]  <= nxt_row;
          open_ff[b] <= nxt_open;
        end
      end
    end
  endgenerate

  // Mode register and command code
  always_comb begin
    nxt_mode     = mode_ff;
    nxt_code     = code_ff;
    nxt_code_vld = 1'b0;
    if (init_load) begin
      nxt_mode = nv_mode_value;
    end else if (cmd == CMD_MRS) begin
      nxt_mode = addr[`MR_WIDTH-1:0];
    end
    if (cmd == CMD_CODE) begin
      nxt_code     = addr[`CODE_MSB:0];
      nxt_code_vld = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff     <= `MR_RESET;
      code_ff     <= 8'h00;
      code_vld_ff <= 1'b0;
    end else if (clk_en) begin
      mode_ff     <= nxt_mode;
      code_ff     <= nxt_code;
      code_vld_ff <= nxt_code_vld;
    end else begin
      code_vld_ff <= 1'b0;
    end
  end

  // Array read port follows the burst column
  assign rd_en   = rd_word;
  assign rd_bank = start_rd ? bank_sel : bbank_ff;
  assign rd_row  = row_ff[rd_bank];
  assign rd_col  = bif.col;

  assign cur_word = cfg_read_sel ? {5'h00, mode_ff} : rd_data;

  always_comb begin
    nxt_pipe[0] = cur_word;
    nxt_pipe[1] = pipe_ff[0];
    nxt_pvld    = {pvld_ff[0], rd_word};
    if (cmd == CMD_BST || cmd == CMD_WR) begin
      nxt_pvld = 2'b00;
    end
    if (cl == `CL_ONE) begin
      nxt_dout = cur_word;
      sel_vld  = rd_word;
    end else if (cl == `CL_TWO) begin
      nxt_dout = pipe_ff[0];
      sel_vld  = pvld_ff[0];
    end else begin
      nxt_dout = pipe_ff[1];
      sel_vld  = pvld_ff[1];
    end
    if (cmd == CMD_BST || cmd == CMD_WR) begin
      sel_vld = 1'b0;
    end
    nxt_oe = sel_vld && !dqm_d1_ff;
    if (!sel_vld) begin
      nxt_dout = dout_ff;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pipe_ff[0] <= 16'h0000;
      pipe_ff[1] <= 16'h0000;
      pvld_ff    <= 2'b00;
      dout_ff    <= 16'h0000;
      oe_ff      <= 1'b0;
      dqm_d1_ff  <= 1'b1;
    end else if (clk_en) begin
      pipe_ff[0] <= nxt_pipe[0];
      pipe_ff[1] <= nxt_pipe[1];
      pvld_ff    <= nxt_pvld;
      dout_ff    <= nxt_dout;
      oe_ff      <= nxt_oe;
      dqm_d1_ff  <= dqm;
    end
  end

  assign nxt_wr_en = wr_word && !dqm;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_en_ff   <= 1'b0;
      wr_bank_ff <= 2'h0;
      wr_row_ff  <= 12'h000;
      wr_col_ff  <= 8'h00;
      wr_data_ff <= 16'h0000;
    end else if (clk_en) begin
      wr_en_ff   <= nxt_wr_en;
      wr_bank_ff <= start_wr ? bank_sel : bbank_ff;
      wr_row_ff  <= row_ff[start_wr ? bank_sel : bbank_ff];
      wr_col_ff  <= bif.col;
      wr_data_ff <= dq_in;
    end else begin
      wr_en_ff   <= 1'b0;
    end
  end

  assign dq_out       = dout_ff;
  assign dq_oe        = oe_ff;
  assign wr_en        = wr_en_ff;
  assign wr_bank      = wr_bank_ff;
  assign wr_row       = wr_row_ff;
  assign wr_col       = wr_col_ff;
  assign wr_data      = wr_data_ff;
  assign cmd_code     = code_ff;
  assign cmd_code_vld = code_vld_ff;
  assign bank_open    = open_ff;
  assign mode_value   = mode_ff;

endmodule

// *** testbench/flash_cmd_checker.sv ***
// Port checker of command decode, mode loads and burst timing
`timescale 1ns/1ps
module flash_cmd_checker (
  input wire logic          clk_sys,
  input wire logic          rst_n,
  input wire logic          clk_en,
  input wire logic          cs_n,
  input wire logic          ras_n,
  input wire logic          cas_n,
  input wire logic          we_n,
  input wire logic [1:0]    bank_sel,
  input wire logic [11:0]   addr,
  input wire logic          dqm,
  input wire logic          init_load,
  input wire logic [10:0]   nv_mode_value,
  input wire logic          hw_code_load_off,
  input wire logic          dq_oe,
  input wire logic          wr_en,
  input wire logic [7:0]    wr_col,
  input wire logic [7:0]    cmd_code,
  input wire logic          cmd_code_vld,
  input wire logic [3:0]    bank_open,
  input wire logic [10:0]   mode_value
);
  wire c     = clk_en && !cs_n;
  wire act   = c && !ras_n && cas_n && we_n;
  wire rd    = c && ras_n && !cas_n && we_n;
  wire wr    = c && ras_n && !cas_n && !we_n;
  wire bst   = c && ras_n && cas_n && !we_n;
  wire code  = c && !ras_n && !cas_n && we_n;
  wire mrs   = c && !ras_n && !cas_n && !we_n;
  wire quiet = !c || (cas_n && (we_n || !ras_n));

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_wr;
    wr && !dqm |=> wr_en && wr_col == $past(addr[7:0]);
  endproperty
  a_wr: assert property (p_wr) else $error("write word lost");
  property p_code;
    code && !hw_code_load_off |=> cmd_code_vld && cmd_code == $past(addr[7:0]);
  endproperty
  a_code: assert property (p_code) else $error("code load bad");
  property p_code_off;
    code && hw_code_load_off |=> !cmd_code_vld;
  endproperty
  a_code_off: assert property (p_code_off) else $error("code not off");
  property p_mode;
    mrs && !init_load |=> mode_value == $past(addr[10:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode load bad");
  property p_init;
    clk_en && init_load |=> mode_value == $past(nv_mode_value);
  endproperty
  a_init: assert property (p_init) else $error("default copy bad");
  property p_act;
    act |=> bank_open[$past(bank_sel)];
  endproperty
  a_act: assert property (p_act) else $error("row not open");
  property p_bst;
    bst |=> !dq_oe;
  endproperty
  a_bst: assert property (p_bst) else $error("burst not stopped");
  property p_lat2;
    rd && mode_value[6:4] == 3'h2 && !dqm ##1 quiet |=> dq_oe;
  endproperty
  a_lat2: assert property (p_lat2) else $error("drive start late");
endmodule
bind sdram_flash_burst_cmd flash_cmd_checker flash_cmd_checker_i (
  .clk_sys, .rst_n, .clk_en, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel,
  .addr, .dqm, .init_load, .nv_mode_value, .hw_code_load_off, .dq_oe,
  .wr_en, .wr_col, .cmd_code, .cmd_code_vld, .bank_open, .mode_value
);

// *** testbench/flash_ctrl_model.sv ***
// Controller model driving command, address, mask and write data pins
`timescale 1ns/1ps
module flash_ctrl_model (
  input wire logic               clk_sys,
  output logic                   cs_n,
  output logic                   ras_n,
  output logic                   cas_n,
  output logic                   we_n,
  output logic [1:0]             bank_sel,
  output logic [11:0]            addr,
  output logic                   dqm,
  output flash_burst_pkg::word_t dq_in
);
  import flash_burst_pkg::*;
  initial begin
    {cs_n, ras_n, cas_n, we_n, dqm} = 5'h1E;
    bank_sel = 2'h1;
    addr = 12'h0;
    dq_in = 16'h0;
  end
  task automatic cmd(input logic [3:0] op, input logic [11:0] a,
                     input logic m, input logic wd, input word_t d,
                     input logic [1:0] bk);
    {cs_n, ras_n, cas_n, we_n} <= op;
    bank_sel <= bk;
    addr <= a;
    dqm <= m;
    // Released data lines toggle rather than hold
    dq_in <= wd ? d : ~dq_in;
    @(posedge clk_sys);
  endtask
endmodule

// *** testbench/sdram_flash_burst_cmd_tb.sv ***
// Self-checking bench of the burst command block
`timescale 1ns/1ps
module sdram_flash_burst_cmd_tb;
  import flash_burst_pkg::*;
  localparam logic [3:0] NOP = 4'h7, ACT = 4'h3, RD = 4'h5, WR = 4'h4;
  localparam logic [3:0] BST = 4'h6, CLS = 4'h2, CODE = 4'h1, MRS = 4'h0;
  localparam logic [3:0] INH = 4'h8;
  logic       clk_sys, rst_n, cs_n, ras_n, cas_n, we_n, dqm, dq_oe, clk_en;
  logic       init_load, hw_code_load_off, cfg_read_sel, rd_en, wr_en;
  logic       cmd_code_vld;
  logic [1:0] bank_sel, rd_bank, wr_bank;
  logic [11:0] addr;
  logic [7:0] cmd_code;
  logic [3:0] bank_open;
  word_t      dq_in, dq_out, rd_data, wr_data;
  row_t       rd_row, wr_row;
  col_t       rd_col, wr_col;
  mode_t      nv_mode_value, mode_value;
  int         fail_count, samples_checked;
  int         cyc = 0;

  sdram_flash_burst_cmd sdram_flash_burst_cmd_i (
    .clk_sys, .rst_n, .clk_en, .cs_n, .ras_n, .cas_n, .we_n,
    .bank_sel, .addr, .dqm, .dq_in, .dq_out, .dq_oe, .init_load,
    .nv_mode_value, .hw_code_load_off, .cfg_read_sel, .rd_en, .rd_bank,
    .rd_row, .rd_col, .rd_data, .wr_en, .wr_bank, .wr_row, .wr_col,
    .wr_data, .cmd_code, .cmd_code_vld, .bank_open, .mode_value
  );
  flash_ctrl_model flash_ctrl_model_i (
    .clk_sys, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel, .addr, .dqm, .dq_in
  );
  // Array word names its own bank, row and column
  assign rd_data = {rd_bank, rd_row[5:0], rd_col};

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      $display("Error %0t timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic go(input logic [3:0] o, input logic [11:0] a = 12'h0,
                    input logic m = 1'b0, input logic wd = 1'b0,
                    input word_t d = 16'h0, input logic [1:0] bk = 2'h1);
    flash_ctrl_model_i.cmd(o, a, m, wd, d, bk);
  endtask

  task automatic rd_burst(input logic [2:0] bl, input logic bt,
                          input logic [2:0] cl, input int n, input col_t col);
    col_t  msk, e;
    mode_t mr;
    msk = bl == 3'h7 ? 8'hFF : (8'h1 << bl) - 8'h1;
    mr = {4'h0, cl, bt, bl};
    go(CLS, 12'h400);
    go(MRS, {1'b0, mr});
    go(ACT, 12'h0A5);
    go(RD, {4'h0, col});
    chk(rd_en, 1'b1);
    chk(mode_value, mr);
    chk(bank_open, 4'h2);
    repeat (cl - 1) go(NOP);
    chk(dq_oe, 1'b0);
    go(NOP);
    for (int k = 0; k < n; k++) begin
      e = bt ? col ^ k[7:0] : col + k[7:0];
      e = (col & ~msk) | (e & msk);
      chk(dq_out, cfg_read_sel ? {5'h0, mr} : {2'h1, 6'h25, e});
      chk(dq_oe, 1'b1);
      go(k == n - 1 && bl == 3'h7 ? BST : NOP);
    end
    if (bl == 3'h7)
      go(NOP);
    chk(dq_oe, 1'b0);
    chk(rd_en, 1'b0);
  endtask

  task automatic wr_burst(input mode_t mr, input int n, input int drop);
    col_t msk, e;
    int   cnt;
    cnt = 0;
    msk = mr[9] ? 8'h0 : mr[2:0] == 3'h7 ? 8'h7 : (8'h1 << mr[2:0]) - 8'h1;
    go(CLS, 12'h400);
    go(MRS, {1'b0, mr});
    go(CODE, 12'hF40);
    go(ACT, 12'h0A5);
    chk(cmd_code, 8'h40);
    go(WR, 12'h00E, drop == 0, 1'b1, 16'hA000);
    for (int k = 1; k < 11; k++) begin
      go(NOP, 12'h0, k == drop, k < 8, 16'hA000 + 16'(k));
      if (wr_en === 1'b1) begin
        e = (8'h0E & ~msk) | ((8'h0E + 8'(k - 1)) & msk);
        chk(wr_col, e);
        chk(wr_data, 16'hA000 + 16'(k - 1));
        chk({wr_bank, wr_row}, {2'h1, 12'h0A5});
        cnt++;
      end
    end
    chk(16'(cnt), 16'(n));
  endtask

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    init_load = 1'b0;
    nv_mode_value = 11'h0;
    hw_code_load_off = 1'b0;
    cfg_read_sel = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    go(NOP);
    chk(mode_value, 11'h020);
    chk(bank_open, 4'h0);
    // Latency 1..3 across lengths; controller frequency assumed permitted
    for (int i = 0; i < 4; i++)
      for (int t = 0; t < 2; t++)
        rd_burst(i[2:0], t[0], 3'(i % 3 + 1), 1 << i, 8'hFD);
    rd_burst(3'h7, 1'b0, 3'h2, 4, 8'hFE);
    go(RD, 12'h0, 1'b1);
    go(NOP);
    go(NOP);
    chk(dq_oe, 1'b0);
    go(BST);
    chk(dq_oe, 1'b1);
    go(NOP);
    go(ACT, 12'h0A5, 1'b0, 1'b0, 16'h0, 2'h2);
    go(CLS, 12'h000);
    go(NOP);
    chk(bank_open, 4'h4);
    cfg_read_sel <= 1'b1;
    rd_burst(3'h0, 1'b0, 3'h1, 1, 8'h10);
    cfg_read_sel <= 1'b0;
    nv_mode_value <= 11'h033;
    init_load <= 1'b1;
    go(NOP);
    init_load <= 1'b0;
    go(NOP);
    chk(mode_value, 11'h033);
    clk_en <= 1'b0;
    go(MRS, 12'h011);
    clk_en <= 1'b1;
    go(INH, 12'h011);
    go(NOP);
    chk(mode_value, 11'h033);
    hw_code_load_off <= 1'b1;
    go(CODE, 12'h055);
    go(NOP);
    chk(cmd_code_vld, 1'b0);
    hw_code_load_off <= 1'b0;
    wr_burst(11'h022, 3, 2);
    wr_burst(11'h027, 8, 99);
    wr_burst(11'h223, 1, 99);
    summarize();
  end
endmodule
